//--- rtl/kpi_unit.sv
// Keypad interrupt unit: pin enables, request latch, acknowledge, mask, event interrupt.
// Assumes break state, break-clear enable and vector acknowledge come from logic on clk.
//
// Operation
// - With break-clear enabled, a flag cleared in break stays cleared afterwards.
// - With break-clear disabled, acknowledge writes during break do not clear the request; mask and sensitivity bits still load.
// - Upper four status bits read zero; writes to them are ignored.
// - Pending flag reads one while a request is latched; reset clears it.
// - Writing one to acknowledge clears the request; it stores nothing.
// - Acknowledge bit always reads zero.
// - Mask bit set keeps the request off the CPU line; reset clears.
// - Sensitivity bit one means edge and level, zero edge only.
// - Each pin-enable bit lets its pin latch requests, or blocks it.
// - Reset clears all pin enables, so no pin is a source.
// - Latch when an enabled pin falls after all were high.
// - Edge-and-level request clears after acknowledge and all pins high.
// - Edge-only request clears at acknowledge; a later edge latches anew.
// - Pin enable forces the pin to input and turns its pull-up on.
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "kpi_defines.svh"

module kpi_unit #(
  parameter int NUM_PINS = `KPI_NUM_PINS
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // Register port
  input  wire logic [`KPI_ADDR_W-1:0]      regAddr,
  input  wire kpi_pkg::kpi_byte_t          regWrData,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output var  kpi_pkg::kpi_byte_t          regRdData,
  // Debug break
  input  wire logic                        breakState,
  input  wire logic                        breakClearEnable,
  // CPU interrupt
  input  wire logic                        vectorAck,
  output var  logic                        keypadIrq,
  // Event interrupt
  output var  logic                        eventIrq,
  // Keypad pins
  input  wire logic [NUM_PINS-1:0]         keyPin,
  output var  logic [NUM_PINS-1:0]         pinForceInput,
  output var  logic [NUM_PINS-1:0]         pullupEn
);
  import kpi_pkg::*;

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  kpi_pin_if #(.NUM_PINS(NUM_PINS)) pinBus ();

  assign pinBus.rawPin = keyPin;

  kpi_sync #(
    .NUM_PINS (NUM_PINS)
  ) u_sync (
    .clk  (clk),
    .rst  (rst),
    .pins (pinBus)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  kpi_state_t                    state;
  logic                          prevAnyLow;
  logic                          modeLevel;
  logic                          irqMask;
  logic [NUM_PINS-1:0]           pinEnable;
  logic [`KPI_NUM_EVENTS-1:0]    evStatus;
  logic [`KPI_NUM_EVENTS-1:0]    evMask;

  kpi_state_t                    next_state;
  logic                          next_prevAnyLow;
  logic                          next_modeLevel;
  logic                          next_irqMask;
  logic [NUM_PINS-1:0]           next_pinEnable;
  logic [`KPI_NUM_EVENTS-1:0]    next_evStatus;
  logic [`KPI_NUM_EVENTS-1:0]    next_evMask;
  kpi_byte_t                     next_regRdData;
  logic                          next_keypadIrq;
  logic                          next_eventIrq;

  // ****************************************************************
  // Decoded strobes and pin conditions
  // ****************************************************************
  logic                          scrWr;
  logic                          penWr;
  logic                          evsWr;
  logic                          evmWr;
  logic                          swAck;
  logic                          ackBlocked;
  logic                          ackNow;
  logic                          anyLow;
  logic                          fallEdge;
  logic                          pending;
  logic                          latchNew;
  logic [`KPI_NUM_EVENTS-1:0]    evSet;
  logic [`KPI_NUM_EVENTS-1:0]    evClr;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  always_comb begin
    scrWr = 1'b0;
    penWr = 1'b0;
    evsWr = 1'b0;
    evmWr = 1'b0;
    if (regWr && regAddr == `KPI_ADDR_SCR) begin
      scrWr = 1'b1;
    end else if (regWr && regAddr == `KPI_ADDR_PEN) begin
      penWr = 1'b1;
    end else if (regWr && regAddr == `KPI_ADDR_EVS) begin
      evsWr = 1'b1;
    end else if (regWr && regAddr == `KPI_ADDR_EVM) begin
      evmWr = 1'b1;
    end
  end

  // ****************************************************************
  // Per-pin qualification
  // ****************************************************************
  // A disabled pin never counts as low, so it can neither latch nor hold a request.
  logic [NUM_PINS-1:0]           pinLow;

  genvar p;
  generate
    for (p = 0; p < NUM_PINS; p++) begin : g_pin
      assign pinLow[p] = pinEnable[p] && !pinBus.syncPin[p];
    end
  endgenerate

  // ****************************************************************
  // Request conditions
  // ****************************************************************
  // Enabling a pin that is already low looks like a fall; software masks first.
  always_comb begin
    anyLow     = |pinLow;
    fallEdge   = anyLow && !prevAnyLow;
    pending    = (state != KPI_IDLE);
    swAck      = scrWr && regWrData[`KPI_SCR_ACK];
    ackBlocked = breakState && !breakClearEnable;
    ackNow     = vectorAck || (swAck && !ackBlocked);
  end

  // ****************************************************************
  // Request state machine
  // ****************************************************************
  // A fall in the same cycle as an acknowledge wins and latches a new request.
  always_comb begin
    next_state = state;
    case (state)
      KPI_IDLE: begin
        if (fallEdge) begin
          next_state = KPI_PEND;
        end
      end
      KPI_PEND: begin
        if (ackNow) begin
          if (fallEdge) begin
            next_state = KPI_PEND;
          end else if (modeLevel && anyLow) begin
            next_state = KPI_WAIT;
          end else begin
            next_state = KPI_IDLE;
          end
        end
      end
      KPI_WAIT: begin
        if (!modeLevel || !anyLow) begin
          next_state = KPI_IDLE;
        end
      end
      default: begin
        next_state = KPI_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Registers and events
  // ****************************************************************
  always_comb begin
    next_prevAnyLow = anyLow;
    next_modeLevel  = modeLevel;
    next_irqMask    = irqMask;
    next_pinEnable  = pinEnable;
    next_evMask     = evMask;

    if (scrWr) begin
      next_modeLevel = regWrData[`KPI_SCR_MODE];
      next_irqMask   = regWrData[`KPI_SCR_MASK];
    end
    if (penWr) begin
      next_pinEnable = regWrData[NUM_PINS-1:0];
    end
    if (evmWr) begin
      next_evMask = regWrData[`KPI_NUM_EVENTS-1:0];
    end

    // Event sources: a fresh latch, and an acknowledge that hit a pending request.
    latchNew = fallEdge && (state != KPI_PEND || ackNow);
    evSet    = '0;
    evSet[`KPI_EV_LATCH] = latchNew;
    evSet[`KPI_EV_ACK]   = ackNow && pending;

    // Write one to clear; a set in the same cycle wins over the clear.
    evClr = evsWr ? regWrData[`KPI_NUM_EVENTS-1:0] : '0;
    next_evStatus = (evStatus & ~evClr) | evSet;

    // Outputs are registered copies of the next state so they line up with it.
    next_keypadIrq = (next_state != KPI_IDLE) && !next_irqMask;
    next_eventIrq  = |(next_evStatus & next_evMask);
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Read data stand for exactly one cycle; unmapped addresses read zero.
  always_comb begin
    next_regRdData = `KPI_RST_BYTE;
    if (regRd && regAddr == `KPI_ADDR_SCR) begin
      next_regRdData[`KPI_SCR_KEYPAD_PENDING_FLAG] = pending;
      next_regRdData[`KPI_SCR_ACK]  = 1'b0;
      next_regRdData[`KPI_SCR_MASK] = irqMask;
      next_regRdData[`KPI_SCR_MODE] = modeLevel;
    end else if (regRd && regAddr == `KPI_ADDR_PEN) begin
      next_regRdData[NUM_PINS-1:0] = pinEnable;
    end else if (regRd && regAddr == `KPI_ADDR_EVS) begin
      next_regRdData[`KPI_NUM_EVENTS-1:0] = evStatus;
    end else if (regRd && regAddr == `KPI_ADDR_EVM) begin
      next_regRdData[`KPI_NUM_EVENTS-1:0] = evMask;
    end
  end

  // ****************************************************************
  // Flip-flops
  // ****************************************************************
  // Reset drops any request even with a pin held low; prevAnyLow resets low, so
  // a pin still low when enabled later is seen as a fresh fall.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state      <= KPI_IDLE;
      prevAnyLow <= `KPI_RST_BIT;
    end else begin
      state      <= next_state;
      prevAnyLow <= next_prevAnyLow;
    end
  end

  // Software-visible control bits.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      modeLevel <= `KPI_RST_BIT;
      irqMask   <= `KPI_RST_BIT;
      pinEnable <= '0;
    end else begin
      modeLevel <= next_modeLevel;
      irqMask   <= next_irqMask;
      pinEnable <= next_pinEnable;
    end
  end

  // Event status and mask.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evStatus <= '0;
      evMask   <= '0;
    end else begin
      evStatus <= next_evStatus;
      evMask   <= next_evMask;
    end
  end

  // Read data.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdData <= `KPI_RST_BYTE;
    end else begin
      regRdData <= next_regRdData;
    end
  end

  // Outputs copy next values, so each comes straight from a flip-flop
  // and changes in the same cycle as the state it reports.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      keypadIrq     <= `KPI_RST_BIT;
      eventIrq      <= `KPI_RST_BIT;
      pinForceInput <= '0;
      pullupEn      <= '0;
    end else begin
      keypadIrq     <= next_keypadIrq;
      eventIrq      <= next_eventIrq;
      pinForceInput <= next_pinEnable;
      pullupEn      <= next_pinEnable;
    end
  end

endmodule : kpi_unit

`default_nettype wire

//--- pkg/kpi_defines.svh
// Register offsets, field positions, reset values and sizes of the keypad interrupt unit.
// Assumes inclusion by bare name from files that also see kpi_pkg.
`ifndef KPI_DEFINES_SVH
`define KPI_DEFINES_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define KPI_NUM_PINS     5
`define KPI_ADDR_W       8
`define KPI_DATA_W       8
`define KPI_NUM_EVENTS   2

// ****************************************************************
// Register offsets
// ****************************************************************
`define KPI_ADDR_SCR     8'h1a
`define KPI_ADDR_PEN     8'h1b
`define KPI_ADDR_EVS     8'h1c
`define KPI_ADDR_EVM     8'h1d

// ****************************************************************
// Status and control fields
// ****************************************************************
`define KPI_SCR_KEYPAD_PENDING_FLAG     3
`define KPI_SCR_ACK      2
`define KPI_SCR_MASK     1
`define KPI_SCR_MODE     0

// ****************************************************************
// Event status fields
// ****************************************************************
`define KPI_EV_LATCH     0
`define KPI_EV_ACK       1

// ****************************************************************
// Reset values
// ****************************************************************
`define KPI_RST_BYTE     8'h00
`define KPI_RST_BIT      1'b0
`define KPI_SYNC_RST     1'b1

`endif

//--- pkg/kpi_pkg.sv
// Types shared by the keypad interrupt unit and its pin synchroniser.
// Assumes nothing of its surroundings.
package kpi_pkg;

  // One register byte on the software port.
  typedef logic [7:0] kpi_byte_t;

  // Request state: idle, latched, acknowledged but pins still low.
  typedef enum logic [2:0] {
    KPI_IDLE = 3'b001,
    KPI_PEND = 3'b010,
    KPI_WAIT = 3'b100
  } kpi_state_t;

endpackage : kpi_pkg

//--- pkg/kpi_pin_if.sv
// Interface that carries keypad pins into the synchroniser and back to the core.
// Assumes the core drives rawPin straight from its pin inputs.
`timescale 1ns/1ps
`default_nettype none

interface kpi_pin_if #(
  parameter int NUM_PINS = 5
);
  logic [NUM_PINS-1:0] rawPin;
  logic [NUM_PINS-1:0] syncPin;

  modport sync (
    input  rawPin,
    output syncPin
  );

  modport core (
    output rawPin,
    input  syncPin
  );
endinterface : kpi_pin_if

`default_nettype wire

//--- rtl/kpi_sync.sv
// Two-flop synchroniser for the asynchronous keypad pins.
// Assumes pins idle high through their pull-ups, so both stages reset high.
`timescale 1ns/1ps
`default_nettype none
`include "kpi_defines.svh"

module kpi_sync #(
  parameter int NUM_PINS = `KPI_NUM_PINS
) (
  // Clock and reset
  input wire logic  clk,
  input wire logic  rst,
  // Pins in, synchronised pins out
  kpi_pin_if.sync   pins
);
  import kpi_pkg::*;

  logic [NUM_PINS-1:0] stageA;
  logic [NUM_PINS-1:0] stageB;
  logic [NUM_PINS-1:0] next_stageA;
  logic [NUM_PINS-1:0] next_stageB;

  // Only stageB looks at stageA, so a metastable first stage never reaches logic.
  genvar i;
  generate
    for (i = 0; i < NUM_PINS; i++) begin : g_pin
      always_comb begin
        next_stageA[i] = pins.rawPin[i];
        next_stageB[i] = stageA[i];
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          stageA[i] <= `KPI_SYNC_RST;
          stageB[i] <= `KPI_SYNC_RST;
        end else begin
          stageA[i] <= next_stageA[i];
          stageB[i] <= next_stageB[i];
        end
      end
    end
  endgenerate

  assign pins.syncPin = stageB;

endmodule : kpi_sync

`default_nettype wire

//--- sim/kpi_keys.sv
// Switch model for the keypad pins: a closed contact pulls its pin low.
// Assumes board pull-ups, so an open contact reads high whatever the enables.
`timescale 1ns/1ps
`default_nettype none

module kpi_keys #(
  parameter int NUM_PINS = 5
) (
  // Contacts
  input  wire logic [NUM_PINS-1:0] press,
  // Pins towards the unit
  output wire logic [NUM_PINS-1:0] keyPin
);
  assign keyPin = ~press;
endmodule : kpi_keys

`default_nettype wire

//--- sim/kpi_unit_chk.sv
// Port checker for the keypad interrupt unit, bound to its top module.
// Assumes kpi_pkg and kpi_defines.svh are visible.
`timescale 1ns/1ps
`default_nettype none
`include "kpi_defines.svh"

module kpi_unit_chk #(
  parameter int NUM_PINS = `KPI_NUM_PINS
) (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    rst,
  // Register port
  input wire logic [`KPI_ADDR_W-1:0]  regAddr,
  input wire kpi_pkg::kpi_byte_t      regWrData,
  input wire logic                    regWr,
  input wire logic                    regRd,
  input wire kpi_pkg::kpi_byte_t      regRdData,
  // Break, interrupts and pins
  input wire logic                    breakState,
  input wire logic                    breakClearEnable,
  input wire logic                    vectorAck,
  input wire logic                    keypadIrq,
  input wire logic                    eventIrq,
  input wire logic [NUM_PINS-1:0]     keyPin,
  input wire logic [NUM_PINS-1:0]     pinForceInput,
  input wire logic [NUM_PINS-1:0]     pullupEn
);
  import kpi_pkg::*;
  // ****************************************************************
  // Shadow of mode and mask, since the checker cannot see inside
  // ****************************************************************
  logic                modeSh, maskSh, next_modeSh, next_maskSh, scrWr;
  logic [NUM_PINS-1:0] enData;
  assign scrWr  = regWr && regAddr == `KPI_ADDR_SCR;
  assign enData = regWrData[NUM_PINS-1:0];
  always_comb begin
    next_modeSh = scrWr ? regWrData[`KPI_SCR_MODE] : modeSh;
    next_maskSh = scrWr ? regWrData[`KPI_SCR_MASK] : maskSh;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      modeSh <= 1'b0;
      maskSh <= 1'b0;
    end else begin
      modeSh <= next_modeSh;
      maskSh <= next_maskSh;
    end
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_SCR_UPPER: assert property (regRd && regAddr == `KPI_ADDR_SCR |=> regRdData[7:4] == 4'h0)
    else $error("upper status bits not zero");
  AST_ACK_READ: assert property (regRd && regAddr == `KPI_ADDR_SCR |=> !regRdData[2])
    else $error("acknowledge bit read back nonzero");
  AST_MASK: assert property (scrWr && regWrData[`KPI_SCR_MASK] |=> ##1 !keypadIrq)
    else $error("masked request reached the interrupt line");
  AST_PEN_COPY: assert property (regWr && regAddr == `KPI_ADDR_PEN |-> ##2
    pinForceInput == $past(enData, 2) && pullupEn == pinForceInput)
    else $error("pin enable outputs differ from written enables");
  AST_RST_CLEAR: assert property ($fell(rst) |-> !pinForceInput && !keypadIrq && !eventIrq)
    else $error("outputs not clear after reset");
  AST_VACK_EDGE: assert property (vectorAck && !modeSh |=> !keypadIrq)
    else $error("vector fetch did not clear edge request");
  AST_LEVEL_HOLD: assert property ((keypadIrq && modeSh && !maskSh && !regWr
    && (~keyPin & pinForceInput) != '0) [*4] |=> keypadIrq)
    else $error("level request dropped while a pin is low");
  AST_BRK_KEEP: assert property (breakState && !breakClearEnable && scrWr && regWrData[2]
    && keypadIrq && !vectorAck && !modeSh && regWrData[1:0] == {maskSh, 1'b0} |=> keypadIrq)
    else $error("acknowledge acted during protected break");
  AST_BRK_CLEAR: assert property (breakState && breakClearEnable && scrWr && regWrData[2]
    && !modeSh && regWrData[1:0] == 2'h0 |=> !keypadIrq)
    else $error("acknowledge ignored during break with clear enabled");
  CVR_LEVEL: cover property (keypadIrq && modeSh);
  CVR_VACK: cover property (vectorAck && keypadIrq);
  CVR_EVENT: cover property (eventIrq);
endmodule : kpi_unit_chk

bind kpi_unit kpi_unit_chk #(.NUM_PINS(NUM_PINS)) i_chk (
  .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
  .regRd(regRd), .regRdData(regRdData), .breakState(breakState),
  .breakClearEnable(breakClearEnable), .vectorAck(vectorAck), .keypadIrq(keypadIrq),
  .eventIrq(eventIrq), .keyPin(keyPin), .pinForceInput(pinForceInput), .pullupEn(pullupEn));

`default_nettype wire

//--- sim/kpi_unit_tb.sv
// Self-checking bench for the keypad interrupt unit with the switch model.
// Assumes the design, the checker and kpi_keys are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "kpi_defines.svh"

module kpi_unit_tb;
  import kpi_pkg::*;
  logic       clk, rst, regWr, regRd, breakState, breakClearEnable, vectorAck;
  logic [7:0] regAddr;
  kpi_byte_t  regWrData, regRdData;
  logic       keypadIrq, eventIrq;
  logic [4:0] keyPin, pinForceInput, pullupEn, press;
  int         err_total, samples_checked;

  kpi_unit i_dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .breakState(breakState),
    .breakClearEnable(breakClearEnable), .vectorAck(vectorAck), .keypadIrq(keypadIrq),
    .eventIrq(eventIrq), .keyPin(keyPin), .pinForceInput(pinForceInput), .pullupEn(pullupEn));
  kpi_keys i_keys (.press(press), .keyPin(keyPin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask : chk
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask : w
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk(n, e, regRdData);
  endtask : rd
  // Waits out the two synchroniser stages and the latch edge before returning.
  task automatic key(input logic [4:0] v);
    @(posedge clk);
    press <= v;
    w(5);
  endtask : key
  task automatic ci(input logic e);
    #1 chk("keypadIrq", {7'h00, e}, {7'h00, keypadIrq});
  endtask : ci
  task automatic ce(input logic e);
    #1 chk("eventIrq", {7'h00, e}, {7'h00, eventIrq});
  endtask : ce
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    {rst, regWr, regRd, breakState, breakClearEnable, vectorAck} = 6'h20;
    {regAddr, regWrData, press} = 21'h000000;
    err_total = 0;
    samples_checked = 0;
    w(3);
    rst <= 1'b0;
    rd(`KPI_ADDR_SCR, 8'h00, "status");
    rd(`KPI_ADDR_PEN, 8'h00, "enables");
    rd(8'h30, 8'h00, "unmapped");
    wr(`KPI_ADDR_SCR, 8'hf7);
    rd(`KPI_ADDR_SCR, 8'h03, "status");
    wr(`KPI_ADDR_SCR, 8'h00);
    wr(`KPI_ADDR_PEN, 8'hff);
    rd(`KPI_ADDR_PEN, 8'h1f, "enables");
    chk("pullupEn", 8'h1f, {3'h0, pullupEn});
    wr(`KPI_ADDR_PEN, 8'h03);
    key(5'h04); ci(1'b0);
    key(5'h00); key(5'h01); ci(1'b1);
    rd(`KPI_ADDR_SCR, 8'h08, "status");
    wr(`KPI_ADDR_SCR, 8'h04); w(2); ci(1'b0);
    key(5'h03); ci(1'b0);
    key(5'h00); key(5'h02); ci(1'b1);
    @(posedge clk) vectorAck <= 1'b1;
    @(posedge clk) vectorAck <= 1'b0;
    w(2); ci(1'b0);
    key(5'h00); key(5'h02); ci(1'b1);
    wr(`KPI_ADDR_SCR, 8'h04); key(5'h00);
    wr(`KPI_ADDR_SCR, 8'h02); key(5'h01); ci(1'b0);
    rd(`KPI_ADDR_SCR, 8'h0a, "status");
    wr(`KPI_ADDR_SCR, 8'h06); key(5'h00);
    wr(`KPI_ADDR_SCR, 8'h01); key(5'h01); ci(1'b1);
    wr(`KPI_ADDR_SCR, 8'h05); w(3); ci(1'b1);
    key(5'h00); ci(1'b0);
    key(5'h01); key(5'h00); ci(1'b1);
    wr(`KPI_ADDR_SCR, 8'h05); w(2); ci(1'b0);
    wr(`KPI_ADDR_SCR, 8'h00);
    @(posedge clk) breakState <= 1'b1;
    key(5'h01); ci(1'b1);
    wr(`KPI_ADDR_SCR, 8'h04); w(2); ci(1'b1);
    @(posedge clk) breakClearEnable <= 1'b1;
    wr(`KPI_ADDR_SCR, 8'h04); w(2); ci(1'b0);
    @(posedge clk) breakState <= 1'b0;
    w(3); ci(1'b0);
    key(5'h00);
    // Earlier latches and acknowledges left both event bits set.
    wr(`KPI_ADDR_EVM, 8'h03); w(2); ce(1'b1);
    wr(`KPI_ADDR_EVS, 8'h03); w(2); ce(1'b0);
    rd(`KPI_ADDR_EVS, 8'h00, "events");
    wr(`KPI_ADDR_EVM, 8'h01); key(5'h01); ce(1'b1);
    wr(`KPI_ADDR_SCR, 8'h04); w(2);
    rd(`KPI_ADDR_EVS, 8'h03, "events");
    wr(`KPI_ADDR_EVM, 8'h00); w(2); ce(1'b0);
    // Mid-run reset with a masked level request pending and the pin still low.
    wr(`KPI_ADDR_SCR, 8'h03); key(5'h00); key(5'h01);
    rd(`KPI_ADDR_SCR, 8'h0b, "status");
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    rd(`KPI_ADDR_SCR, 8'h00, "status");
    rd(`KPI_ADDR_PEN, 8'h00, "enables");
    chk("pinForceInput", 8'h00, {3'h0, pinForceInput});
    ci(1'b0);
    key(5'h00);
    give_verdict;
  end

  initial begin
    #50000;
    err_total++;
    give_verdict;
  end
endmodule : kpi_unit_tb

`default_nettype wire
